// ---- src/lvc_defines.svh ----
`ifndef LVC_DEFINES_SVH
`define LVC_DEFINES_SVH

// register offsets
`define LVC_OFF_SEL 8'hE5
`define LVC_OFF_CTRL 8'hE6
`define LVC_OFF_SPARE 8'hE7
`define LVC_OFF_READ 8'hE8

// reset values
`define LVC_SEL_RST 4'h0
`define LVC_CTRL_RST 8'h00
`define LVC_COUNT_RST 16'h0000

// writable field masks
`define LVC_SEL_MASK 8'h0F
`define LVC_CTRL_MASK 8'h1F

// selector codes that name no channel
`define LVC_SEL_NONE_LO 4'h0
`define LVC_SEL_NONE_HI 4'hF

// software hold time of a counter clear
`define LVC_CLK_PERIOD_NS 5
`define LVC_CLR_HOLD_NS 1000
`define LVC_CLR_HOLD_CYC ((`LVC_CLR_HOLD_NS + `LVC_CLK_PERIOD_NS - 1) / `LVC_CLK_PERIOD_NS)

`endif

// ---- src/lvc_pkg.sv ----
package lvc_pkg;

  // counter control register layout, msb first
  typedef struct packed {
    logic [2:0] rsvd;
    logic every_channel_clear;
    logic every_channel_snapshot;
    logic count_byte_choice;
    logic single_channel_snapshot;
    logic single_channel_clear;
  } lvc_ctrl_t;

  // one host access on the microprocessor port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lvc_req_t;

  typedef logic [3:0] lvc_sel_t;

endpackage

// ---- src/lvc_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lvc_defines.svh"

module lvc_chan #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic viol,
  input wire logic clear,
  input wire logic snap,
  output logic [W-1:0] count,
  output logic [W-1:0] hold,
  output logic ovf
);

  localparam logic [W-1:0] MAX = {W{1'b1}};

  logic [W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////
  // running counter: clear first, then saturating increment
  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = '0;
    else if (viol && (count != MAX))
      next_count = count + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (ce)
      count <= next_count;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ovf <= 1'b0;
    else if (ce)
      ovf <= (next_count == MAX);
  end

  ////////////////////////////////////////////////////////////////////////
  // holding register keeps its snapshot until the next one
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hold <= '0;
    else if (ce && snap)
      hold <= count;
  end

  ////////////////////////////////////////////////////////////////////////
  a_clear_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && clear |=> count == '0)
    else $error("counter not zero after clear");

  a_saturate_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && !clear && count == MAX |=> count == MAX)
    else $error("saturated counter wrapped");

  a_ovf_track: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ovf == (count == MAX))
    else $error("overflow flag disagrees with counter");

  a_hold_stable: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(ce && snap) |=> $stable(hold))
    else $error("holding register moved without snapshot");

  a_snap_copy: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && snap |=> hold == $past(count))
    else $error("snapshot did not copy count");

endmodule

`default_nettype wire

// ---- src/lvc_readout.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lvc_defines.svh"

// Overview of operation
// - byte choice bit picks low byte at zero, high byte at one; resets low.
// - writing one to single snapshot copies selected running count to hold.
// - single clear bit zeroes only the selected channel's running counter.
// - single snapshot, single clear and readback all act on the selector's channel.
// - readback register shows chosen byte of selected channel's held count.
// - after reset nothing is selected, so readback reads zero.
// - spare register at the next address has no function, reads zero.
// - each counter is sixteen bits, saturates, and flags overflow.
// - selector codes 1 to 14 pick channels 0 to 13; 0 and 15 none.
// - every channel clear zeroes all fourteen counters while held at one.
// - every channel snapshot latches all fourteen counters at once.
module lvc_readout
  import lvc_pkg::*;
#(
  parameter int NCH = 14,
  parameter int CW = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire lvc_req_t req,
  input wire logic [NCH-1:0] line_code_violation,
  output logic [7:0] rdata,
  output logic [NCH-1:0] count_overflow
);

  localparam logic [3:0] NCH_CODE = 4'(NCH);

  lvc_sel_t sel;
  lvc_ctrl_t ctrl;
  logic sel_valid;
  logic [3:0] sel_idx;
  logic ctrl_wr;
  lvc_ctrl_t wr_ctrl;
  logic single_snap_pulse;
  logic every_snap_pulse;
  logic [NCH-1:0] clear_vec;
  logic [NCH-1:0] snap_vec;
  logic [CW-1:0] count [NCH];
  logic [CW-1:0] hold [NCH];
  logic [7:0] read_byte;
  logic [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////
  // channel selector decode
  always_comb
  begin
    sel_valid = (sel != `LVC_SEL_NONE_LO) && (sel != `LVC_SEL_NONE_HI)
      && (sel <= NCH_CODE);
    sel_idx = sel - 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // host registers
  assign ctrl_wr = ce && req.wr && (req.addr == `LVC_OFF_CTRL);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sel <= `LVC_SEL_RST;
    else if (ce && req.wr && (req.addr == `LVC_OFF_SEL))
      sel <= lvc_sel_t'(req.wdata & `LVC_SEL_MASK);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= lvc_ctrl_t'(`LVC_CTRL_RST);
    else if (ctrl_wr)
      ctrl <= lvc_ctrl_t'(req.wdata & `LVC_CTRL_MASK);
  end

  ////////////////////////////////////////////////////////////////////////
  // snapshots fire on the write that carries a one
  always_comb
  begin
    wr_ctrl = lvc_ctrl_t'(req.wdata);
    single_snap_pulse = ctrl_wr
      && wr_ctrl.single_channel_snapshot;
    every_snap_pulse = ctrl_wr
      && wr_ctrl.every_channel_snapshot;
  end

  // clears act for as long as their bit stays at one
  always_comb
  begin
    clear_vec = '0;
    snap_vec = '0;
    for (int i = 0; i < NCH; i++)
    begin
      if (ctrl.every_channel_clear)
        clear_vec[i] = 1'b1;
      else if (ctrl.single_channel_clear && sel_valid
               && (sel_idx == 4'(i)))
        clear_vec[i] = 1'b1;
      if (every_snap_pulse)
        snap_vec[i] = 1'b1;
      else if (single_snap_pulse && sel_valid && (sel_idx == 4'(i)))
        snap_vec[i] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel counters
  for (genvar g = 0; g < NCH; g++)
  begin : g_chan
    lvc_chan #(
      .W(CW)
    ) u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .viol(line_code_violation[g]),
      .clear(clear_vec[g]),
      .snap(snap_vec[g]),
      .count(count[g]),
      .hold(hold[g]),
      .ovf(count_overflow[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // readback byte from the selected holding register
  always_comb
  begin
    read_byte = 8'h00;
    if (sel_valid)
    begin
      if (ctrl.count_byte_choice)
        read_byte = hold[sel_idx][15:8];
      else
        read_byte = hold[sel_idx][7:0];
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (req.addr)
      `LVC_OFF_SEL:
        next_rdata = {4'h0, sel};
      `LVC_OFF_CTRL:
        next_rdata = ctrl;
      `LVC_OFF_SPARE:
        next_rdata = 8'h00;
      `LVC_OFF_READ:
        next_rdata = read_byte;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (ce && req.rd)
      rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_read_of(logic [7:0] a);
    ce && req.rd && (req.addr == a);
  endsequence

  sequence s_ctrl_write_one;
    ctrl_wr && req.wdata[1];
  endsequence

  a_sel_decode: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sel_valid == ((sel >= 4'h1) && (sel <= 4'hE)))
    else $error("selector decode wrong");

  a_read_byte: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_read_of(`LVC_OFF_READ) |=> rdata == $past(read_byte))
    else $error("readback byte wrong");

  a_byte_low: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sel_valid && !ctrl.count_byte_choice
      |-> read_byte == hold[sel_idx][7:0])
    else $error("low byte not presented");

  a_byte_high: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sel_valid && ctrl.count_byte_choice
      |-> read_byte == hold[sel_idx][15:8])
    else $error("high byte not presented");

  a_none_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !sel_valid |-> read_byte == 8'h00)
    else $error("unselected readback not zero");

  a_spare_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_read_of(`LVC_OFF_SPARE) |=> rdata == 8'h00)
    else $error("spare register not zero");

  a_clear_only_sel: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !ctrl.every_channel_clear |-> $onehot0(clear_vec))
    else $error("clear touched other channels");

  a_all_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctrl.every_channel_clear |-> &clear_vec)
    else $error("global clear missed a channel");

  a_single_snap: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_ctrl_write_one ##0 sel_valid |-> snap_vec[sel_idx])
    else $error("selected channel not snapshotted");

  a_all_snap: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && req.wdata[3] |-> &snap_vec)
    else $error("global snapshot missed a channel");

endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lvc_defines.svh"

module tb
  import lvc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  lvc_req_t req = '0;
  logic ce = 1'b1;
  logic [13:0] line_code_violation = 14'h0000;
  logic [7:0] rdata;
  logic [13:0] count_overflow;
  int fail_count = 0;
  int samples_checked = 0;

  always #2.5 clk_sys = ~clk_sys;

  lvc_readout u_lvc_readout (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .req(req),
    .line_code_violation(line_code_violation),
    .rdata(rdata),
    .count_overflow(count_overflow)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    @(negedge clk_sys);
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  // violations on the masked lines for n sampled cycles
  task automatic viol(input logic [13:0] m, input int n);
    @(posedge clk_sys);
    line_code_violation <= m;
    repeat (n) @(posedge clk_sys);
    line_code_violation <= 14'h0000;
  endtask

  task automatic snap(input logic [7:0] code);
    wr(`LVC_OFF_SEL, code);
    wr(`LVC_OFF_CTRL, 8'h02);
  endtask

  // read the held count of a channel, low byte then high byte
  task automatic cc(input logic [7:0] code, input logic [15:0] e);
    wr(`LVC_OFF_SEL, code);
    wr(`LVC_OFF_CTRL, 8'h00);
    rd(`LVC_OFF_READ, e[7:0]);
    wr(`LVC_OFF_CTRL, 8'h04);
    rd(`LVC_OFF_READ, e[15:8]);
    wr(`LVC_OFF_CTRL, 8'h00);
  endtask

  // clear bit held for a full microsecond
  task automatic clr(input logic [7:0] v);
    wr(`LVC_OFF_CTRL, v);
    repeat (`LVC_CLR_HOLD_CYC) @(posedge clk_sys);
    wr(`LVC_OFF_CTRL, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    rd(`LVC_OFF_SEL, 8'h00);
    rd(`LVC_OFF_CTRL, 8'h00);
    rd(`LVC_OFF_SPARE, 8'h00);
    rd(`LVC_OFF_READ, 8'h00);
    rd(8'h10, 8'h00);
  endtask

  task automatic s_single;
    viol(14'h2001, 3);
    viol(14'h2000, 300);
    snap(8'h01);
    cc(8'h01, 16'h0003);
    cc(8'h0E, 16'h0000);
    snap(8'h0E);
    cc(8'h0E, 16'h012F);
    viol(14'h2000, 5);
    cc(8'h0E, 16'h012F);
    snap(8'h0E);
    cc(8'h0E, 16'h0134);
  endtask

  task automatic s_clear;
    wr(`LVC_OFF_SEL, 8'h0E);
    clr(8'h01);
    cc(8'h0E, 16'h0134);
    snap(8'h0E);
    cc(8'h0E, 16'h0000);
    snap(8'h01);
    cc(8'h01, 16'h0003);
  endtask

  task automatic s_all;
    viol(14'h3FFF, 2);
    wr(`LVC_OFF_CTRL, 8'h08);
    cc(8'h01, 16'h0005);
    cc(8'h08, 16'h0002);
    cc(8'h0E, 16'h0002);
    clr(8'h10);
    wr(`LVC_OFF_CTRL, 8'h08);
    cc(8'h01, 16'h0000);
    cc(8'h08, 16'h0000);
  endtask

  task automatic s_none;
    viol(14'h0001, 4);
    snap(8'h01);
    wr(`LVC_OFF_SEL, 8'hFF);
    rd(`LVC_OFF_SEL, 8'h0F);
    rd(`LVC_OFF_READ, 8'h00);
    wr(`LVC_OFF_SEL, 8'h00);
    rd(`LVC_OFF_READ, 8'h00);
    wr(`LVC_OFF_SPARE, 8'hFF);
    rd(`LVC_OFF_SPARE, 8'h00);
    wr(`LVC_OFF_READ, 8'hA5);
    cc(8'h01, 16'h0004);
  endtask

  // with the clock enable low nothing may move
  task automatic s_freeze;
    @(posedge clk_sys);
    ce <= 1'b0;
    viol(14'h0001, 3);
    wr(`LVC_OFF_CTRL, 8'h03);
    wr(`LVC_OFF_SEL, 8'h0E);
    rd(`LVC_OFF_SEL, 8'h00);
    @(posedge clk_sys);
    ce <= 1'b1;
    cc(8'h01, 16'h0004);
    snap(8'h01);
    cc(8'h01, 16'h0004);
  endtask

  task automatic s_sat;
    viol(14'h0004, 65534);
    @(negedge clk_sys);
    chk({2'b00, count_overflow}, 16'h0000);
    viol(14'h0004, 4);
    @(negedge clk_sys);
    chk({2'b00, count_overflow}, 16'h0004);
    snap(8'h03);
    cc(8'h03, 16'hFFFF);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #450us;
    fail_count++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_reset();
    s_single();
    s_clear();
    s_all();
    s_none();
    s_freeze();
    s_sat();
    stop_test();
  end
endmodule

`default_nettype wire
